// [design/bmo_top.sv]
// Boot sequencer, memory map, data memory and oscillator enables
//
// How it works
// - Any reset starts fetch at 0x000
// - Taken interrupt vectors fetch to 0x010
// - Top 32 words 0x7E0-0x7FF reserved
// - User code at 0x001-0x00F, 0x011-0x7DF
// - Data memory allows byte and bit access
// - Stack lives in memory at stack pointer
// - Byte pointer reaches all 128 data bytes
// - Three oscillators enabled by separate bits
// - Both RC oscillators on after boot
// - Slow boot holds off about 32 ms
// - Fast boot holds off about 550 us
// - Fast wake resumes after 45 slow ticks
// - Slow wake resumes after 3000 slow ticks
// - System clock is fast RC over 2..32 (undivided for unlisted codes), or slow RC or crystal undivided
// - Fast RC trimmed through calibration register
// - Clock-mode write switches source at once
//
// The APB slave port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "bmo_defines.svh"
module bmo_top #(
   parameter int BOOT_SLOW_CYC =
      `BMO_BOOT_SLOW_MS * 1000000 / `BMO_CLK_NS,
   parameter int BOOT_FAST_CYC =
      `BMO_BOOT_FAST_US * 1000 / `BMO_CLK_NS,
   parameter int WAKE_FAST_T = `BMO_WAKE_FAST_T,
   parameter int WAKE_SLOW_T = `BMO_WAKE_SLOW_T,
   parameter int TW = 22,
   parameter int DM_DEPTH = `BMO_DM_DEPTH
) (
   // Clock, reset, enable
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   input wire logic ce_i,
   // Register bus
   input wire bmo_pkg::bmo_apb_req_t apb_req_i,
   output var bmo_pkg::bmo_apb_rsp_t apb_rsp_o,
   // Strap and core events
   input wire logic boot_fast_i,
   input wire logic irq_take_i,
   input wire logic sleep_req_i,
   input wire logic wake_event_i,
   input wire logic [10:0] pc_i,
   // Oscillator ticks
   input wire logic fast_tick_i,
   input wire logic slow_tick_i,
   input wire logic xtal_tick_i,
   // Fetch control
   output logic cpu_run_o,
   output logic fetch_load_o,
   output logic [10:0] fetch_addr_o,
   output logic pc_sys_area_o,
   // Oscillator control
   output logic fast_rc_en_o,
   output logic slow_rc_en_o,
   output logic xtal_en_o,
   output logic [7:0] fast_rc_trim_o,
   output logic sys_tick_o,
   output bmo_pkg::bmo_src_t clk_src_o
);
   import bmo_pkg::*;

   ////////////////////////////////////////////////////////////////////
   // Registers and state
   bmo_state_t state_q;
   logic boot_fast_q;
   logic wake_slow_q;
   logic [7:0] clkmd_q;
   logic [7:0] xtal_q;
   logic [7:0] sp_q;
   logic [6:0] dm_addr_q;
   logic [2:0] bit_idx_q;
   logic [31:0] prdata_q;
   logic pready_q;
   logic pslverr_q;
   logic [7:0] dmem [0:DM_DEPTH-1];

   ////////////////////////////////////////////////////////////////////
   // Bus decode
   wire setup = apb_req_i.psel && !apb_req_i.penable;
   wire access = apb_req_i.psel && apb_req_i.penable && pready_q;
   wire wr = access && apb_req_i.pwrite;
   wire rd = access && !apb_req_i.pwrite;
   wire [7:0] off = apb_req_i.paddr[7:0];
   wire top_ok = (apb_req_i.paddr[31:6] == `BMO_ADDR_TOP);
   wire hit_cm = top_ok && (off == `BMO_OFF_CLKMD);
   wire hit_xt = top_ok && (off == `BMO_OFF_XTAL);
   wire hit_tr = top_ok && (off == `BMO_OFF_TRIM);
   wire hit_wk = top_ok && (off == `BMO_OFF_WAKE);
   wire hit_st = top_ok && (off == `BMO_OFF_STAT);
   wire hit_da = top_ok && (off == `BMO_OFF_DMADR);
   wire hit_dd = top_ok && (off == `BMO_OFF_DMDAT);
   wire hit_db = top_ok && (off == `BMO_OFF_DMBIT);
   wire hit_in = top_ok && (off == `BMO_OFF_IND);
   wire hit_sp = top_ok && (off == `BMO_OFF_SP);
   wire hit_sk = top_ok && (off == `BMO_OFF_STK);
   wire mapped = hit_cm || hit_xt || hit_tr || hit_wk || hit_st ||
                 hit_da || hit_dd || hit_db || hit_in || hit_sp ||
                 hit_sk;
   wire [7:0] wdat = apb_req_i.pwdata[7:0];

   ////////////////////////////////////////////////////////////////////
   // Data memory paths
   wire [7:0] cur_byte = dmem[dm_addr_q];
   // Pointer byte is 8 bits; the top bit falls outside 128 bytes
   wire [6:0] ind_ptr = cur_byte[6:0];
   wire [7:0] ind_byte = dmem[ind_ptr];
   wire [7:0] sp_dec = sp_q - 8'h01;
   wire [7:0] pop_byte = dmem[sp_dec[6:0]];
   wire [7:0] bit_merged;
   genvar g;
   generate
      for (g = 0; g < 8; g++) begin : g_bit
         assign bit_merged[g] = (wdat[2:0] == 3'(g)) ? wdat[3] :
                                cur_byte[g];
      end
   endgenerate
   wire mem_we = wr && (hit_dd || hit_db || hit_in || hit_sk);
   wire [6:0] mem_idx = hit_in ? ind_ptr :
                        hit_sk ? sp_q[6:0] : dm_addr_q;
   wire [7:0] mem_val = hit_db ? bit_merged : wdat;

   always_ff @(posedge core_clk_i) begin
      if (ce_i && mem_we) begin
         dmem[mem_idx] <= mem_val;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Read data
   wire [7:0] stat_byte = {1'b0, pc_sys_area_o, boot_fast_q,
                           state_q};
   wire [7:0] rd_byte =
      hit_cm ? clkmd_q :
      hit_xt ? xtal_q :
      hit_tr ? fast_rc_trim_o :
      hit_wk ? {7'h00, wake_slow_q} :
      hit_st ? stat_byte :
      hit_da ? {1'b0, dm_addr_q} :
      hit_dd ? cur_byte :
      hit_db ? {7'h00, cur_byte[bit_idx_q]} :
      hit_in ? ind_byte :
      hit_sp ? sp_q :
      hit_sk ? pop_byte : 8'h00;

   // Zero-wait slave: data is caught in setup, answered in access
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         prdata_q <= 32'h00000000;
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
      end else if (ce_i) begin
         pready_q <= setup;
         pslverr_q <= setup && !mapped;
         if (setup) begin
            prdata_q <= {24'h000000, rd_byte};
         end
      end
   end

   assign apb_rsp_o = '{prdata: prdata_q, pready: pready_q,
                        pslverr: pslverr_q};

   ////////////////////////////////////////////////////////////////////
   // Configuration registers
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         clkmd_q <= `BMO_CLKMD_RST;
         xtal_q <= `BMO_XTAL_RST;
         fast_rc_trim_o <= `BMO_TRIM_RST;
         wake_slow_q <= 1'b0;
         dm_addr_q <= 7'h00;
         bit_idx_q <= 3'h0;
      end else if (ce_i && wr) begin
         if (hit_cm) begin
            clkmd_q <= wdat;
         end
         if (hit_xt) begin
            xtal_q <= wdat;
         end
         if (hit_tr) begin
            fast_rc_trim_o <= wdat;
         end
         if (hit_wk) begin
            wake_slow_q <= wdat[0];
         end
         if (hit_da) begin
            dm_addr_q <= wdat[6:0];
         end
         if (hit_db) begin
            bit_idx_q <= wdat[2:0];
         end
      end
   end

   // Stack pointer: push on write, pop on read of the stack port
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sp_q <= 8'h00;
      end else if (ce_i) begin
         if (wr && hit_sp) begin
            sp_q <= wdat;
         end else if (wr && hit_sk) begin
            sp_q <= sp_q + 8'h01;
         end else if (rd && hit_sk) begin
            sp_q <= sp_dec;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Oscillator enables
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         fast_rc_en_o <= 1'b0;
         slow_rc_en_o <= 1'b0;
         xtal_en_o <= 1'b0;
      end else if (ce_i) begin
         fast_rc_en_o <= clkmd_q[`BMO_CM_FRC_EN];
         slow_rc_en_o <= clkmd_q[`BMO_CM_SRC_EN];
         xtal_en_o <= xtal_q[`BMO_XT_EN];
      end
   end

   bmo_clk_switch u_switch (
      .core_clk_i(core_clk_i),
      .rst_n_i(rst_n_i),
      .ce_i(ce_i),
      .clkmd_i(clkmd_q),
      .xtal_en_i(xtal_q[`BMO_XT_EN]),
      .fast_tick_i(fast_tick_i),
      .slow_tick_i(slow_tick_i),
      .xtal_tick_i(xtal_tick_i),
      .sys_tick_o(sys_tick_o),
      .src_o(clk_src_o)
   );

   ////////////////////////////////////////////////////////////////////
   // Boot and wake sequencer
   logic tmr_start;
   logic [TW-1:0] tmr_len;
   logic tmr_tick;
   logic tmr_done;
   wire in_por = (state_q == BMO_ST_POR);
   wire in_boot = (state_q == BMO_ST_BOOT);
   wire in_run = (state_q == BMO_ST_RUN);
   wire in_sleep = (state_q == BMO_ST_SLEEP);
   wire in_wake = (state_q == BMO_ST_WAKE);
   wire boot_fast_now = boot_fast_i;
   wire [TW-1:0] boot_len = boot_fast_now ? TW'(BOOT_FAST_CYC) :
                            TW'(BOOT_SLOW_CYC);
   wire [TW-1:0] wake_len = wake_slow_q ? TW'(WAKE_SLOW_T) :
                            TW'(WAKE_FAST_T);
   assign tmr_start = in_por || (in_sleep && wake_event_i);
   assign tmr_len = in_por ? boot_len : wake_len;
   // Boot counts core cycles, wake counts slow RC periods
   assign tmr_tick = in_boot ? 1'b1 : slow_tick_i;

   bmo_delay_timer #(
      .TW(TW)
   ) u_timer (
      .core_clk_i(core_clk_i),
      .rst_n_i(rst_n_i),
      .ce_i(ce_i),
      .start_i(tmr_start),
      .len_i(tmr_len),
      .tick_i(tmr_tick),
      .busy_o(),
      .done_o(tmr_done)
   );

   bmo_state_t state_d;
   always_comb begin
      state_d = state_q;
      case (state_q)
         BMO_ST_POR: begin
            state_d = BMO_ST_BOOT;
         end
         BMO_ST_BOOT: begin
            if (tmr_done) begin
               state_d = BMO_ST_RUN;
            end
         end
         BMO_ST_RUN: begin
            if (sleep_req_i) begin
               state_d = BMO_ST_SLEEP;
            end
         end
         BMO_ST_SLEEP: begin
            if (wake_event_i) begin
               state_d = BMO_ST_WAKE;
            end
         end
         BMO_ST_WAKE: begin
            if (tmr_done) begin
               state_d = BMO_ST_RUN;
            end
         end
         default: begin
            state_d = BMO_ST_POR;
         end
      endcase
   end

   // The reset pin is trusted to meet its least pulse width
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_q <= BMO_ST_POR;
         boot_fast_q <= 1'b0;
      end else if (ce_i) begin
         state_q <= state_d;
         if (in_por) begin
            boot_fast_q <= boot_fast_i;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Fetch control
   wire boot_done = in_boot && tmr_done;
   wire take_irq = in_run && irq_take_i && !sleep_req_i;
   wire pc_sys = (pc_i >= `BMO_SYS_LO) && (pc_i <= `BMO_SYS_HI);
   wire pc_user = (pc_i <= `BMO_USER_HI) &&
                  (pc_i != `BMO_RESET_VEC) &&
                  (pc_i != `BMO_IRQ_VEC);

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cpu_run_o <= 1'b0;
         fetch_load_o <= 1'b0;
         fetch_addr_o <= `BMO_RESET_VEC;
         pc_sys_area_o <= 1'b0;
      end else if (ce_i) begin
         cpu_run_o <= (state_d == BMO_ST_RUN);
         fetch_load_o <= boot_done || take_irq;
         if (boot_done) begin
            fetch_addr_o <= `BMO_RESET_VEC;
         end else if (take_irq) begin
            fetch_addr_o <= `BMO_IRQ_VEC;
         end
         // Flags a fetch from the area kept for system data
         pc_sys_area_o <= in_run && pc_sys && !pc_user;
      end
   end

   logic unused_ok;
   assign unused_ok = in_wake;
endmodule : bmo_top
`default_nettype wire

// [design/bmo_defines.svh]
// Constants of the boot, memory map and oscillator enable block
`ifndef BMO_DEFINES_SVH
`define BMO_DEFINES_SVH
// Program memory map
`define BMO_RESET_VEC 11'h000
`define BMO_IRQ_VEC 11'h010
`define BMO_USER_HI 11'h7DF
`define BMO_SYS_LO 11'h7E0
`define BMO_SYS_HI 11'h7FF
// Data memory
`define BMO_DM_DEPTH 128
`define BMO_DM_AW 7
// Register byte offsets
`define BMO_OFF_CLKMD 8'h00
`define BMO_OFF_XTAL 8'h04
`define BMO_OFF_TRIM 8'h08
`define BMO_OFF_WAKE 8'h0C
`define BMO_OFF_STAT 8'h10
`define BMO_OFF_DMADR 8'h14
`define BMO_OFF_DMDAT 8'h18
`define BMO_OFF_DMBIT 8'h1C
`define BMO_OFF_IND 8'h20
`define BMO_OFF_SP 8'h24
`define BMO_OFF_STK 8'h28
`define BMO_ADDR_TOP 26'h0
// Fields and reset values
`define BMO_CM_FRC_EN 4
`define BMO_CM_SRC_EN 2
`define BMO_XT_EN 7
`define BMO_CLKMD_RST 8'h1C
`define BMO_XTAL_RST 8'h00
`define BMO_TRIM_RST 8'h80
// Clock mode select codes, clock-mode bits 7:5 and 3
`define BMO_MD_DIV2 4'h2
`define BMO_MD_DIV4 4'h0
`define BMO_MD_DIV8 4'h3
`define BMO_MD_DIV16 4'h1
`define BMO_MD_DIV32 4'h7
`define BMO_MD_SLOW 4'hE
`define BMO_MD_XTAL 4'hA
// Timing
`define BMO_CLK_NS 10
`define BMO_BOOT_SLOW_MS 32
`define BMO_BOOT_FAST_US 550
`define BMO_WAKE_FAST_T 45
`define BMO_WAKE_SLOW_T 3000
`define BMO_EXT_RST_US 120
`endif

// [design/bmo_pkg.sv]
// Types of the boot, memory map and oscillator enable block
package bmo_pkg;
   typedef struct packed {
      logic [31:0] paddr;
      logic psel;
      logic penable;
      logic pwrite;
      logic [31:0] pwdata;
   } bmo_apb_req_t;
   typedef struct packed {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } bmo_apb_rsp_t;
   typedef enum logic [4:0] {
      BMO_ST_POR = 5'b00001,
      BMO_ST_BOOT = 5'b00010,
      BMO_ST_RUN = 5'b00100,
      BMO_ST_SLEEP = 5'b01000,
      BMO_ST_WAKE = 5'b10000
   } bmo_state_t;
   typedef enum logic [2:0] {
      BMO_SRC_FAST = 3'b001,
      BMO_SRC_SLOW = 3'b010,
      BMO_SRC_XTAL = 3'b100
   } bmo_src_t;
endpackage : bmo_pkg

// [design/bmo_delay_timer.sv]
// Down counter for boot-up and wake-up hold-off
`timescale 1ns/1ps
`default_nettype none
module bmo_delay_timer #(
   parameter int TW = 22
) (
   // Clock and reset
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   input wire logic ce_i,
   // Control
   input wire logic start_i,
   input wire logic [TW-1:0] len_i,
   input wire logic tick_i,
   // Status
   output logic busy_o,
   output logic done_o
);
   logic [TW-1:0] cnt_q;
   wire last = (cnt_q == TW'(1));
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cnt_q <= '0;
         busy_o <= 1'b0;
         done_o <= 1'b0;
      end else if (ce_i) begin
         done_o <= 1'b0;
         if (start_i) begin
            cnt_q <= len_i;
            busy_o <= 1'b1;
         end else if (busy_o && tick_i) begin
            cnt_q <= cnt_q - TW'(1);
            busy_o <= !last;
            done_o <= last;
         end
      end
   end
endmodule : bmo_delay_timer
`default_nettype wire

// [design/bmo_clk_switch.sv]
// System clock source select and divider, as a tick stream
`timescale 1ns/1ps
`default_nettype none
`include "bmo_defines.svh"
module bmo_clk_switch (
   // Clock and reset
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   input wire logic ce_i,
   // Configuration
   input wire logic [7:0] clkmd_i,
   input wire logic xtal_en_i,
   // Oscillator ticks
   input wire logic fast_tick_i,
   input wire logic slow_tick_i,
   input wire logic xtal_tick_i,
   // System clock
   output logic sys_tick_o,
   output bmo_pkg::bmo_src_t src_o
);
   import bmo_pkg::*;
   logic [3:0] md_q;
   logic [4:0] cnt_q;
   wire [3:0] md = {clkmd_i[7:5], clkmd_i[3]};
   wire is_slow = (md == `BMO_MD_SLOW);
   wire is_xtal = (md == `BMO_MD_XTAL);
   wire [4:0] div_last =
      (md == `BMO_MD_DIV2) ? 5'h01 :
      (md == `BMO_MD_DIV4) ? 5'h03 :
      (md == `BMO_MD_DIV8) ? 5'h07 :
      (md == `BMO_MD_DIV16) ? 5'h0F :
      (md == `BMO_MD_DIV32) ? 5'h1F : 5'h00;
   wire frc_on = clkmd_i[`BMO_CM_FRC_EN];
   wire src_on = clkmd_i[`BMO_CM_SRC_EN];
   // A stopped source gives no ticks; software must keep it running
   wire src_tick = is_slow ? (slow_tick_i && src_on) :
                   is_xtal ? (xtal_tick_i && xtal_en_i) :
                   (fast_tick_i && frc_on);
   wire changed = (md != md_q);
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         md_q <= `BMO_MD_DIV16;
         cnt_q <= 5'h00;
         sys_tick_o <= 1'b0;
         src_o <= BMO_SRC_FAST;
      end else if (ce_i) begin
         md_q <= md;
         src_o <= is_slow ? BMO_SRC_SLOW :
                  is_xtal ? BMO_SRC_XTAL : BMO_SRC_FAST;
         // Restart the divider so the first new period is whole
         if (changed) begin
            cnt_q <= 5'h00;
            sys_tick_o <= 1'b0;
         end else if (src_tick && cnt_q >= div_last) begin
            cnt_q <= 5'h00;
            sys_tick_o <= 1'b1;
         end else begin
            cnt_q <= src_tick ? cnt_q + 5'h01 : cnt_q;
            sys_tick_o <= 1'b0;
         end
      end
   end
endmodule : bmo_clk_switch
`default_nettype wire

// [tb/bmo_top_asserts.sv]
// Port assertions for the boot, memory map and oscillator block
`timescale 1ns/1ps
`default_nettype none
module bmo_top_asserts (
   // Clock and reset
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   // Inputs
   input wire bmo_pkg::bmo_apb_req_t apb_req_i,
   input wire logic irq_take_i,
   input wire logic sleep_req_i,
   input wire logic [10:0] pc_i,
   // Outputs
   input wire bmo_pkg::bmo_apb_rsp_t apb_rsp_o,
   input wire logic cpu_run_o,
   input wire logic fetch_load_o,
   input wire logic [10:0] fetch_addr_o,
   input wire logic pc_sys_area_o,
   input wire logic fast_rc_en_o,
   input wire logic slow_rc_en_o,
   input wire logic xtal_en_o,
   input wire logic [7:0] fast_rc_trim_o
);
   import bmo_pkg::*;
   wire logic setup_w = apb_req_i.psel & ~apb_req_i.penable;
   wire logic wr_w = apb_req_i.psel & apb_req_i.penable &
      apb_req_i.pwrite & apb_rsp_o.pready;
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!rst_n_i);
   sequence s_wr(logic [31:0] off);
      wr_w && apb_req_i.paddr == off;
   endsequence
   // Boot load: a load while the core was not yet running
   sequence s_boot_load;
      fetch_load_o && !$past(cpu_run_o);
   endsequence
   a_zero_wait:
   assert property (setup_w |=> apb_rsp_o.pready)
      else $error("pready missing in access cycle");
   a_err_unmapped:
   assert property (setup_w && apb_req_i.paddr[31:6] != 26'h0 |=>
      apb_rsp_o.pslverr && apb_rsp_o.prdata == 32'h0)
      else $error("unmapped access not refused");
   a_boot_vector:
   assert property (s_boot_load |-> fetch_addr_o == 11'h000)
      else $error("boot fetch not at zero");
   a_boot_rc_on:
   assert property (s_boot_load |-> fast_rc_en_o && slow_rc_en_o)
      else $error("rc oscillators off after boot");
   a_irq_vector:
   assert property (cpu_run_o && irq_take_i && !sleep_req_i |=>
      fetch_load_o && fetch_addr_o == 11'h010)
      else $error("interrupt vector wrong");
   a_sys_area:
   assert property (cpu_run_o && !sleep_req_i && pc_i >= 11'h7E0 |=>
      pc_sys_area_o)
      else $error("reserved area not flagged");
   a_user_area:
   assert property (pc_i < 11'h7E0 |=> !pc_sys_area_o)
      else $error("user area flagged");
   a_rc_enable:
   assert property (s_wr(32'h0) |-> ##2
      fast_rc_en_o == $past(apb_req_i.pwdata[4], 2) &&
      slow_rc_en_o == $past(apb_req_i.pwdata[2], 2))
      else $error("rc enable not following clock mode");
   a_xtal_enable:
   assert property (s_wr(32'h4) |-> ##2
      xtal_en_o == $past(apb_req_i.pwdata[7], 2))
      else $error("crystal enable not following register");
   a_trim_write:
   assert property (s_wr(32'h8) |=>
      fast_rc_trim_o == $past(apb_req_i.pwdata[7:0]))
      else $error("trim output not updated");
endmodule : bmo_top_asserts
bind bmo_top bmo_top_asserts u_asserts (.core_clk_i, .rst_n_i,
   .apb_req_i, .irq_take_i, .sleep_req_i, .pc_i, .apb_rsp_o, .cpu_run_o,
   .fetch_load_o, .fetch_addr_o, .pc_sys_area_o, .fast_rc_en_o,
   .slow_rc_en_o, .xtal_en_o, .fast_rc_trim_o);
`default_nettype wire

// [tb/tb.sv]
// Self-checking bench for the boot, memory map and oscillator block
`timescale 1ns/1ps
`default_nettype none
module tb;
   import bmo_pkg::*;
   logic core_clk_i, rst_n_i, ce_i, boot_fast_i, irq_take_i;
   logic sleep_req_i, wake_event_i, fast_tick_i, slow_tick_i, xtal_tick_i;
   logic [10:0] pc_i;
   logic [10:0] fetch_addr_o;
   bmo_apb_req_t apb_req_i;
   bmo_apb_rsp_t apb_rsp_o;
   logic cpu_run_o, fetch_load_o, pc_sys_area_o, sys_tick_o;
   logic fast_rc_en_o, slow_rc_en_o, xtal_en_o;
   logic [7:0] fast_rc_trim_o;
   bmo_src_t clk_src_o;
   logic [1:0] tcnt = 2'h0;
   logic [7:0] rdat;
   logic rerr;
   int errors, n_checks;
   // Boot and slow wake counts shortened to keep the run brief
   bmo_top #(.BOOT_SLOW_CYC(50), .BOOT_FAST_CYC(20), .WAKE_SLOW_T(10))
   DUT (.core_clk_i, .rst_n_i, .ce_i, .apb_req_i, .apb_rsp_o,
      .boot_fast_i, .irq_take_i, .sleep_req_i, .wake_event_i, .pc_i,
      .fast_tick_i, .slow_tick_i, .xtal_tick_i, .cpu_run_o, .fetch_load_o,
      .fetch_addr_o, .pc_sys_area_o, .fast_rc_en_o, .slow_rc_en_o,
      .xtal_en_o, .fast_rc_trim_o, .sys_tick_o, .clk_src_o);
   initial begin
      core_clk_i = 1'b0;
      forever #5 core_clk_i = ~core_clk_i;
   end
   // Slow source ticks every 2 cycles, crystal every 4
   always @(posedge core_clk_i) begin
      tcnt <= tcnt + 2'h1;
      slow_tick_i <= tcnt[0];
      xtal_tick_i <= (tcnt == 2'h3);
   end
   ////////////////////////////////////////////////////////////////////
   task automatic chk(input logic ok, input string msg);
      n_checks++;
      if (ok !== 1'b1) begin
         errors++;
         $display("unexpected %0t %s", $time, msg);
      end
   endtask : chk
   task automatic tick(input int n);
      repeat (n) @(posedge core_clk_i);
   endtask : tick
   task automatic apb(input logic w, input logic [31:0] a,
      input logic [7:0] d);
      int k;
      @(posedge core_clk_i);
      apb_req_i <= '{paddr: a, psel: 1'b1, penable: 1'b0, pwrite: w,
         pwdata: {24'h0, d}};
      @(posedge core_clk_i);
      apb_req_i.penable <= 1'b1;
      // Wait as long as it takes; only the watchdog ends a hang
      k = 0;
      do begin
         @(posedge core_clk_i);
         k++;
      end while (apb_rsp_o.pready !== 1'b1);
      rdat = apb_rsp_o.prdata[7:0];
      rerr = apb_rsp_o.pslverr;
      chk(k == 1, "wait states in access");
      apb_req_i.psel <= 1'b0;
      apb_req_i.penable <= 1'b0;
   endtask : apb
   task automatic rdchk(input logic [31:0] a, input logic [7:0] e,
      input string msg);
      apb(1'b0, a, 8'h00);
      chk(rdat === e && rerr === 1'b0, msg);
   endtask : rdchk
   ////////////////////////////////////////////////////////////////////
   task automatic boot_run(input logic bf, input int hold, input int cyc);
      int n;
      @(posedge core_clk_i);
      boot_fast_i <= bf;
      rst_n_i <= 1'b0;
      tick(hold);
      rst_n_i <= 1'b1;
      n = 0;
      while (n < 200 && fetch_load_o !== 1'b1) begin
         @(posedge core_clk_i);
         n++;
      end
      chk(n >= cyc && n <= cyc + 4, "boot hold-off");
      chk(fetch_addr_o === 11'h000 && cpu_run_o === 1'b1, "boot");
      chk(fast_rc_en_o === 1'b1 && slow_rc_en_o === 1'b1, "rc on");
   endtask : boot_run
   task automatic t_regs;
      rdchk(32'h00, 8'h1C, "clock mode reset");
      rdchk(32'h04, 8'h00, "crystal reset");
      rdchk(32'h08, 8'h80, "trim reset");
      rdchk(32'h10, 8'h24, "status run");
      apb(1'b1, 32'h10, 8'hFF);
      rdchk(32'h10, 8'h24, "status read only");
      apb(1'b1, 32'h08, 8'h5A);
      tick(1);
      chk(fast_rc_trim_o === 8'h5A, "trim out");
      rdchk(32'h08, 8'h5A, "trim read");
      apb(1'b0, 32'h2C, 8'h00);
      chk(rerr === 1'b1 && rdat === 8'h00, "hole read");
      apb(1'b1, 32'h40, 8'h77);
      chk(rerr === 1'b1, "high write");
   endtask : t_regs
   task automatic t_mem;
      apb(1'b1, 32'h14, 8'h05);
      apb(1'b1, 32'h18, 8'hA5);
      rdchk(32'h18, 8'hA5, "byte");
      apb(1'b1, 32'h1C, 8'h09);
      rdchk(32'h1C, 8'h01, "bit read");
      apb(1'b1, 32'h1C, 8'h00);
      rdchk(32'h18, 8'hA6, "bit write");
      apb(1'b1, 32'h18, 8'hFF);
      apb(1'b1, 32'h14, 8'h7F);
      apb(1'b1, 32'h18, 8'h3C);
      apb(1'b1, 32'h14, 8'h05);
      rdchk(32'h20, 8'h3C, "indirect to top byte");
      apb(1'b1, 32'h24, 8'h40);
      apb(1'b1, 32'h28, 8'h11);
      apb(1'b1, 32'h28, 8'h22);
      rdchk(32'h24, 8'h42, "sp after push");
      rdchk(32'h28, 8'h22, "pop 1");
      rdchk(32'h28, 8'h11, "pop 2");
      rdchk(32'h24, 8'h40, "sp after pop");
      apb(1'b1, 32'h14, 8'h40);
      rdchk(32'h18, 8'h11, "stack in memory");
   endtask : t_mem
   task automatic t_osc;
      // Never stop the running source in the write that moves off it
      apb(1'b1, 32'h00, 8'hF4);
      apb(1'b1, 32'h00, 8'hE4);
      tick(2);
      chk(fast_rc_en_o === 1'b0 && slow_rc_en_o === 1'b1, "fast off");
      apb(1'b1, 32'h04, 8'h80);
      tick(2);
      chk(xtal_en_o === 1'b1 && fast_rc_en_o === 1'b0, "xtal on");
      apb(1'b1, 32'h00, 8'hF4);
      apb(1'b1, 32'h00, 8'h1C);
      apb(1'b1, 32'h00, 8'h18);
      tick(2);
      chk(fast_rc_en_o === 1'b1 && slow_rc_en_o === 1'b0, "slow off");
   endtask : t_osc
   task automatic t_clk;
      logic [3:0] codes [7] = '{4'h2, 4'h0, 4'h3, 4'h1, 4'h7, 4'hE, 4'hA};
      int pers [7] = '{2, 4, 8, 16, 32, 2, 4};
      int i, n;
      bmo_src_t s;
      for (i = 0; i < 7; i++) begin
         s = codes[i] == 4'hE ? BMO_SRC_SLOW :
            codes[i] == 4'hA ? BMO_SRC_XTAL : BMO_SRC_FAST;
         apb(1'b1, 32'h00, {codes[i][3:1], 1'b1, codes[i][0], 3'b100});
         // This edge still shows a tick of the old divider
         @(posedge core_clk_i);
         n = 0;
         do begin
            @(posedge core_clk_i);
            n++;
         end while (n < 100 && sys_tick_o !== 1'b1);
         chk(n <= 2 * pers[i] + 2, "switch late");
         chk(clk_src_o === s, "source");
         n = 0;
         do begin
            @(posedge core_clk_i);
            n++;
         end while (n < 100 && sys_tick_o !== 1'b1);
         chk(n == pers[i], "tick period");
      end
      apb(1'b1, 32'h00, 8'h1C);
   endtask : t_clk
   task automatic t_pc;
      logic [10:0] pcs [4] = '{11'h7E0, 11'h7DF, 11'h7FF, 11'h011};
      logic exp [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
      int i;
      for (i = 0; i < 4; i++) begin
         pc_i <= pcs[i];
         tick(3);
         chk(pc_sys_area_o === exp[i], "system area flag");
      end
      pc_i <= 11'h000;
   endtask : t_pc
   task automatic t_irq;
      @(posedge core_clk_i);
      irq_take_i <= 1'b1;
      @(posedge core_clk_i);
      irq_take_i <= 1'b0;
      repeat (4) begin
         @(posedge core_clk_i);
         if (fetch_load_o === 1'b1) break;
      end
      chk(fetch_load_o === 1'b1 && fetch_addr_o === 11'h010, "irq");
   endtask : t_irq
   task automatic t_wake(input logic [7:0] cfg, input int n_t);
      int n;
      logic seen;
      apb(1'b1, 32'h0C, cfg);
      @(posedge core_clk_i);
      sleep_req_i <= 1'b1;
      @(posedge core_clk_i);
      sleep_req_i <= 1'b0;
      tick(3);
      chk(cpu_run_o === 1'b0, "sleep");
      // Interrupt during sleep must be ignored
      irq_take_i <= 1'b1;
      wake_event_i <= 1'b1;
      @(posedge core_clk_i);
      irq_take_i <= 1'b0;
      wake_event_i <= 1'b0;
      n = 0;
      seen = 1'b0;
      while (n < 200 && cpu_run_o !== 1'b1) begin
         @(posedge core_clk_i);
         n++;
         seen = seen | fetch_load_o;
      end
      chk(n >= 2 * n_t - 2 && n <= 2 * n_t + 4, "wake delay");
      chk(seen === 1'b0, "fetch load on wake");
   endtask : t_wake
   ////////////////////////////////////////////////////////////////////
   task automatic finish_test;
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : finish_test
   initial begin
      #1000000;
      errors++;
      finish_test;
   end
   initial begin
      {rst_n_i, boot_fast_i, irq_take_i, sleep_req_i, wake_event_i} = '0;
      {ce_i, fast_tick_i} = 2'h3;
      pc_i = 11'h000;
      apb_req_i = '0;
      errors = 0;
      n_checks = 0;
      boot_run(1'b1, 4, 20);
      t_regs;
      t_mem;
      t_osc;
      t_clk;
      t_pc;
      t_irq;
      t_wake(8'h00, 45);
      t_wake(8'h01, 10);
      boot_run(1'b0, 12000, 50);
      finish_test;
   end
endmodule : tb
`default_nettype wire
